// *** logic/mssho_core.sv ***
// Executor for secondary-page moves, halt, subtract and nibble exchange
`default_nettype none
module mssho_core (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Instruction request
	input wire mssho_pkg::mssho_req_type req,
	// Side loading of file registers, peek addresses, watchdog tick and wake
	input wire logic file_load_en,
	input wire logic [mssho_pkg::FILE_AW-1:0] file_load_addr,
	input wire logic [7:0] file_load_data,
	input wire logic [mssho_pkg::FILE_AW-1:0] file_peek_addr,
	input wire logic [mssho_pkg::SEC_AW-1:0] sec_peek_addr,
	input wire logic watchdog_tick,
	input wire logic wake,
	// Observed state
	output logic req_ready,
	output logic [7:0] working_register,
	output logic [7:0] file_peek_data,
	output logic [7:0] sec_peek_data,
	output mssho_pkg::mssho_flags_type flags,
	output logic halt_mode,
	output logic [7:0] watchdog_counter,
	output logic [7:0] watchdog_divider
);
	import mssho_pkg::*;

	// All state in one record so reset and update stay together
	typedef struct packed {
		logic [FILE_DEPTH-1:0][7:0] files;
		logic [SEC_DEPTH-1:0][7:0] sec;
		logic [7:0] work;
		mssho_flags_type flg;
		logic halt;
		logic [7:0] wdog;
		logic [7:0] wdiv;
		logic [7:0] file_peek;
		logic [7:0] sec_peek;
	} mssho_state_type;

	mssho_state_type state_ff;
	mssho_state_type nxt_state;
	logic accept;
	logic [7:0] src_byte;
	logic [7:0] swapped;
	logic [SEC_AW-1:0] sec_idx;
	mssho_sub_type sub_res;

	// Borrow-free subtraction: carry out means no borrow
	function automatic mssho_sub_type sub_calc(input logic [7:0] f, input logic [7:0] w);
		logic [8:0] full;
		logic [4:0] low;
		mssho_sub_type r;
		full = {1'h0, f} + {1'h0, ~w} + 9'h001;
		low = {1'h0, f[3:0]} + {1'h0, ~w[3:0]} + 5'h01;
		r.diff = full[7:0];
		r.carry = full[8];
		r.half_carry_flag = low[4];
		return r;
	endfunction

	// No instruction runs while halted
	assign accept = req.valid && !state_ff.halt;
	assign req_ready = !state_ff.halt;
	assign src_byte = state_ff.files[req.operand];
	// Upper operand bits are ignored for the secondary page
	assign sec_idx = req.operand[SEC_AW-1:0];
	assign swapped = {src_byte[3:0], src_byte[7:4]};
	assign sub_res = sub_calc(src_byte, state_ff.work);

	// One combinational pass builds the whole next state
	always_comb begin
		nxt_state = state_ff;
		// Watchdog advances only while awake or halted, never while being cleared
		if (watchdog_tick) begin
			nxt_state.wdiv = state_ff.wdiv + 8'h01;
			if (state_ff.wdiv == DIV_LAST) begin
				nxt_state.wdog = state_ff.wdog + 8'h01;
			end
		end
		if (wake) begin
			nxt_state.halt = 1'h0;
		end
		// Side load yields to an instruction in the same cycle
		if (file_load_en && !accept) begin
			nxt_state.files[file_load_addr] = file_load_data;
		end
		if (accept) begin
			case (req.code)
				MSSHO_OP_READ_SEC: begin
					nxt_state.work = state_ff.sec[sec_idx];
				end
				MSSHO_OP_WRITE_SEC: begin
					nxt_state.sec[sec_idx] = state_ff.work;
				end
				MSSHO_OP_HALT: begin
					// Clearing wins over a tick in the same cycle
					nxt_state.wdog = BYTE_ZERO;
					nxt_state.wdiv = BYTE_ZERO;
					nxt_state.halt = 1'h1;
					nxt_state.flg.time_out_status_flag = 1'h1;
					nxt_state.flg.power_down_status_flag = 1'h0;
				end
				MSSHO_OP_SUB: begin
					// Carry flags read as no borrow, not as a raw borrow bit
					nxt_state.flg.zero = (sub_res.diff == BYTE_ZERO);
					nxt_state.flg.carry = sub_res.carry;
					nxt_state.flg.half_carry_flag = sub_res.half_carry_flag;
					if (req.dest == DEST_FILE) begin
						nxt_state.files[req.operand] = sub_res.diff;
					end else begin
						nxt_state.work = sub_res.diff;
					end
				end
				MSSHO_OP_SWAP: begin
					if (req.dest == DEST_FILE) begin
						nxt_state.files[req.operand] = swapped;
					end else begin
						nxt_state.work = swapped;
					end
				end
				default: begin
					nxt_state.halt = state_ff.halt;
				end
			endcase
		end
		// Peek ports show the state after this edge is stored
		nxt_state.file_peek = nxt_state.files[file_peek_addr];
		nxt_state.sec_peek = nxt_state.sec[sec_peek_addr];
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			// Reset leaves time-out and power-down flags high
			state_ff <= '0;
			state_ff.work <= WORK_RST;
			state_ff.flg.time_out_status_flag <= TO_RST;
			state_ff.flg.power_down_status_flag <= PD_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign working_register = state_ff.work;
	assign file_peek_data = state_ff.file_peek;
	assign sec_peek_data = state_ff.sec_peek;
	assign flags = state_ff.flg;
	assign halt_mode = state_ff.halt;
	assign watchdog_counter = state_ff.wdog;
	assign watchdog_divider = state_ff.wdiv;

	// Checks on the executed instructions
	a_sec_read_value: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && req.code == MSSHO_OP_READ_SEC |=> working_register == $past(state_ff.sec[sec_idx]) && $stable(flags))
		else $error("secondary read wrong");
	a_sec_write_value: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && req.code == MSSHO_OP_WRITE_SEC |=> state_ff.sec[$past(sec_idx)] == $past(state_ff.work) && $stable(flags))
		else $error("secondary write wrong");
	a_halt_watchdog_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && req.code == MSSHO_OP_HALT |=> watchdog_counter == BYTE_ZERO && watchdog_divider == BYTE_ZERO && halt_mode)
		else $error("halt did not clear watchdog");
	a_halt_status_flags: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && req.code == MSSHO_OP_HALT |=> flags.time_out_status_flag && !flags.power_down_status_flag
		&& flags.zero == $past(flags.zero) && flags.carry == $past(flags.carry)
		&& flags.half_carry_flag == $past(flags.half_carry_flag))
		else $error("halt status flags wrong");
	a_sub_zero_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && req.code == MSSHO_OP_SUB |=> flags.zero == ($past(sub_res.diff) == BYTE_ZERO))
		else $error("subtract zero flag wrong");
	a_sub_dest_select: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && req.code == MSSHO_OP_SUB && req.dest == DEST_FILE
		|=> state_ff.files[$past(req.operand)] == $past(sub_res.diff) && $stable(working_register))
		else $error("subtract file write wrong");
	a_swap_nibbles: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && req.code == MSSHO_OP_SWAP && req.dest == DEST_WORK
		|=> working_register == {$past(src_byte[3:0]), $past(src_byte[7:4])} && $stable(flags))
		else $error("swap result wrong");
	a_swap_file_store: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && req.code == MSSHO_OP_SWAP && req.dest == DEST_FILE
		|=> state_ff.files[$past(req.operand)] == $past(swapped) && $stable(working_register))
		else $error("swap file store wrong");
	a_sub_borrow_flags: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && req.code == MSSHO_OP_SUB
		|=> flags.carry == ($past(src_byte) >= $past(state_ff.work))
		&& flags.half_carry_flag == ($past(src_byte[3:0]) >= $past(state_ff.work[3:0])))
		else $error("subtract borrow flags wrong");
	a_halted_ignores_req: assert property (@(posedge mclk) disable iff (!rst_n)
		halt_mode && req.valid && !wake |=> $stable(working_register) && $stable(flags))
		else $error("request ran while halted");

	// Subtract into the working register leaves the file byte intact
	a_sub_work_dest: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && req.code == MSSHO_OP_SUB && req.dest == DEST_WORK
		|=> working_register == 8'($past(src_byte) - $past(state_ff.work))
		&& state_ff.files[$past(req.operand)] == $past(src_byte))
		else $error("subtract working destination wrong");

	// Exchange back into a file register touches no flag
	a_swap_keeps_flags: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && req.code == MSSHO_OP_SWAP && req.dest == DEST_FILE |=> $stable(flags))
		else $error("swap changed flags");

	// Halted core must refuse work at once, so ready drops on the next edge
	a_halt_drops_ready: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && req.code == MSSHO_OP_HALT |=> !req_ready && $stable(working_register))
		else $error("halt left core ready");

	// Secondary write only reads the working register
	a_sec_write_work: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && req.code == MSSHO_OP_WRITE_SEC |=> $stable(working_register))
		else $error("secondary write changed working register");

	// Secondary read leaves the page itself alone
	a_sec_read_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
		accept && req.code == MSSHO_OP_READ_SEC |=> $stable(state_ff.sec))
		else $error("secondary read changed the page");
endmodule : mssho_core
`default_nettype wire

// *** logic/mssho_pkg.sv ***
// Shared types and constants for the secondary-page, halt, subtract and swap executor
`default_nettype none
package mssho_pkg;
	localparam int FILE_DEPTH = 64;
	localparam int SEC_DEPTH = 16;
	localparam int FILE_AW = 6;
	localparam int SEC_AW = 4;
	localparam logic DEST_WORK = 1'h0;
	localparam logic DEST_FILE = 1'h1;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] DIV_LAST = 8'hFF;
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic TO_RST = 1'h1;
	localparam logic PD_RST = 1'h1;
	localparam int OP_CYCLES = 1;

	typedef enum logic [2:0] {
		MSSHO_OP_NONE = 3'b000,
		MSSHO_OP_READ_SEC = 3'b001,
		MSSHO_OP_WRITE_SEC = 3'b010,
		MSSHO_OP_HALT = 3'b011,
		MSSHO_OP_SUB = 3'b100,
		MSSHO_OP_SWAP = 3'b101
	} mssho_op_type;

	typedef struct packed {
		logic valid;
		mssho_op_type code;
		logic [FILE_AW-1:0] operand;
		logic dest;
	} mssho_req_type;

	typedef struct packed {
		logic zero;
		logic half_carry_flag;
		logic carry;
		logic time_out_status_flag;
		logic power_down_status_flag;
	} mssho_flags_type;

	typedef struct packed {
		logic [7:0] diff;
		logic half_carry_flag;
		logic carry;
	} mssho_sub_type;
endpackage : mssho_pkg
`default_nettype wire

// *** testbench/mssho_core_test.sv ***
// Self-checking bench for the secondary-page, halt, subtract and swap executor
`default_nettype none
module mssho_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	import mssho_pkg::*;
	logic mclk = 0, rst_n = 0, file_load_en = 0, watchdog_tick = 0, wake = 0;
	mssho_req_type req = '0;
	logic [5:0] file_load_addr = '0, file_peek_addr = '0;
	logic [3:0] sec_peek_addr = 4'hF;
	logic [7:0] file_load_data = '0, work, fpeek, speek, wcnt, wdiv;
	mssho_flags_type flags, fl;
	logic ready, halted;
	int err_count = 0, total_checks = 0;
	always #2.5 mclk = ~mclk;
	mssho_core dut (.mclk(mclk), .rst_n(rst_n), .req(req), .file_load_en(file_load_en),
		.file_load_addr(file_load_addr), .file_load_data(file_load_data), .file_peek_addr(file_peek_addr),
		.sec_peek_addr(sec_peek_addr), .watchdog_tick(watchdog_tick), .wake(wake), .req_ready(ready),
		.working_register(work), .file_peek_data(fpeek), .sec_peek_data(speek), .flags(flags),
		.halt_mode(halted), .watchdog_counter(wcnt), .watchdog_divider(wdiv));
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic op(input mssho_op_type c, input logic [5:0] a, input logic d);
		@(posedge mclk);
		req <= '{1'h1, c, a, d};
		file_peek_addr <= a;
		@(posedge mclk);
		req.valid <= 1'h0;
		#1;
	endtask
	task automatic load(input logic [5:0] a, input logic [7:0] v);
		@(posedge mclk);
		file_load_en <= 1'h1;
		file_load_addr <= a;
		file_load_data <= v;
		@(posedge mclk);
		file_load_en <= 1'h0;
	endtask
	// Working register has no direct load, so go through a swap
	task automatic set_work(input logic [7:0] v);
		load(6'h3E, {v[3:0], v[7:4]});
		op(MSSHO_OP_SWAP, 6'h3E, DEST_WORK);
	endtask
	task automatic t_sub;
		logic [7:0] f [4] = '{8'h05, 8'h06, 8'h06, 8'h10};
		logic [7:0] w [4] = '{8'h06, 8'h05, 8'h06, 8'h01};
		logic [7:0] d;
		for (int i = 0; i < 4; i++) begin
			load(6'h3F, f[i]);
			set_work(w[i]);
			op(MSSHO_OP_SUB, 6'h3F, i[0]);
			d = f[i] - w[i];
			chk("diff", i[0] ? fpeek : work, d);
			chk("other", i[0] ? work : fpeek, i[0] ? w[i] : f[i]);
			chk("zdc", {5'h0, flags[4:2]}, {5'h0, d == 8'h00, f[i][3:0] >= w[i][3:0], f[i] >= w[i]});
		end
		$display("sub test done");
	endtask
	task automatic t_sec;
		fl = flags;
		set_work(8'h55);
		op(MSSHO_OP_WRITE_SEC, 6'h3F, DEST_WORK);
		chk("sec", speek, 8'h55);
		set_work(8'h00);
		op(MSSHO_OP_READ_SEC, 6'h0F, DEST_WORK);
		chk("read", work, 8'h55);
		load(6'h00, 8'hA5);
		op(MSSHO_OP_SWAP, 6'h00, DEST_FILE);
		chk("swap", fpeek, 8'h5A);
		chk("flags", {3'h0, flags}, {3'h0, fl});
		$display("secondary page and swap test done");
	endtask
	task automatic t_halt;
		@(posedge mclk);
		watchdog_tick <= 1'h1;
		repeat (300) @(posedge mclk);
		#1;
		chk("wdog", {wcnt[3:0], 4'h0} | {4'h0, wcnt[7:4]}, 8'h10);
		chk("div", wdiv, 8'h2C);
		op(MSSHO_OP_HALT, 6'h00, DEST_WORK);
		chk("cnt", wcnt, 8'h00);
		chk("div", wdiv, 8'h00);
		chk("to pd", {6'h0, flags[1:0]}, 8'h02);
		chk("kept", {5'h0, flags[4:2]}, 8'h01);
		chk("halt", {6'h0, halted, ready}, 8'h02);
		op(MSSHO_OP_SWAP, 6'h00, DEST_WORK);
		chk("ignored", work, 8'h55);
		@(posedge mclk);
		watchdog_tick <= 1'h0;
		wake <= 1'h1;
		@(posedge mclk);
		wake <= 1'h0;
		#1;
		chk("awake", {7'h0, halted}, 8'h00);
		$display("halt test done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'h1;
		t_sub();
		t_sec();
		t_halt();
		final_report();
	end
	// Whole run is about 400 cycles; allow ample margin
	initial begin
		#20000;
		err_count++;
		final_report();
	end
endmodule // mssho_core_test
`default_nettype wire
